// ===== rtl/opdec_pkg.sv
// Opcode fields, reset values and carrier types for the opcode execute block.
// Assumes a single core clock and a fetch unit that presents one word per cycle.
package opdec_pkg;
   localparam int STACK_DEPTH_DEF = 31;
   localparam int PC_W = 21;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [20:0] PC_STEP = 21'h000002;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic STATUS_BIT_RST = 1'h1;
   // Byte-op selectors in bits 11:10
   localparam logic [1:0] SEL_ROT_LEFT = 2'h1;
   localparam logic [1:0] SEL_ROT_RIGHT = 2'h0;
   localparam logic [1:0] SEL_SUB_F_FROM_A_B = 2'h1;
   localparam logic [1:0] SEL_SUB_A_FROM_F_B = 2'h2;
   localparam logic [1:0] SEL_SUB_A_FROM_F = 2'h3;
   // Top nibbles, then sub-fields of bits 11:9 and 11:8
   localparam logic [3:0] NIB_CONTROL = 4'h0;
   localparam logic [3:0] NIB_ROT_CARRY = 4'h3;
   localparam logic [3:0] NIB_ROT_PLAIN = 4'h4;
   localparam logic [3:0] NIB_SUB = 4'h5;
   localparam logic [3:0] NIB_BIT_TOGGLE = 4'h7;
   localparam logic [3:0] NIB_BIT_SET = 4'h8;
   localparam logic [3:0] NIB_BIT_CLEAR = 4'h9;
   localparam logic [3:0] NIB_TEST_CLEAR = 4'hA;
   localparam logic [3:0] NIB_TEST_SET = 4'hB;
   localparam logic [3:0] NIB_REL = 4'hD;
   localparam logic [3:0] NIB_BRANCH = 4'hE;
   localparam logic [3:0] NIB_SECOND = 4'hF;
   localparam logic [2:0] SUB_CALL = 3'h6;
   localparam logic [3:0] SUB_GOTO = 4'hF;
   localparam logic [3:0] SUB_LIT_RETURN = 4'hC;
   // Whole-word control codes; the two returns match bits 15:1 only
   localparam logic [15:0] W_STANDBY = 16'h0003;
   localparam logic [15:0] W_WDT_CLEAR = 16'h0004;
   localparam logic [15:0] W_PUSH = 16'h0005;
   localparam logic [15:0] W_POP = 16'h0006;
   localparam logic [15:0] W_SOFT_RESET = 16'h00FF;
   localparam logic [14:0] W_IRQ_RETURN = 15'h0008;
   localparam logic [14:0] W_SUB_RETURN = 15'h0009;

   typedef struct packed {
      logic [15:0] word;
      logic        valid;
      logic [7:0]  file_data;
      logic [7:0]  pin_data;
      logic        is_port;
      logic        is_timer_zero_count;
   } op_in_t;

   typedef struct packed {
      logic c;
      logic dc;
      logic z;
      logic ov;
      logic n;
   } flags_t;

   localparam flags_t FLAGS_RST = 5'h00;

   typedef struct packed {
      logic        en;
      logic [11:0] addr;
      logic [7:0]  data;
   } file_wr_t;

   typedef enum logic [1:0] {
      ST_EXEC   = 2'b00,
      ST_DEAD   = 2'b01,
      ST_SECOND = 2'b10,
      ST_SKIP   = 2'b11
   } stage_t;
endpackage : opdec_pkg

// ===== rtl/opcode_exec.sv
// Decode and execute of rotates, subtracts, bit ops and control flow.
// Assumes op is valid combinationally for the address on pc, file and pin data read already.
`timescale 1ns/10ps
`default_nettype none
module opcode_exec #(
   parameter int STACK_DEPTH = opdec_pkg::STACK_DEPTH_DEF
) (
   // Clock and reset
   input  wire logic                                  core_clk,
   input  wire logic                                  srst,
   // Fetched word with its operand
   input  wire opdec_pkg::op_in_t                     op,
   input  wire logic [3:0]                            bank_select,
   input  wire logic                                  prescaler_assigned,
   input  wire logic                                  wake,
   // Data path results
   output var  opdec_pkg::file_wr_t                   file_wr,
   output logic [7:0]                                 working_accumulator,
   output var  opdec_pkg::flags_t                     flags,
   // Program flow
   output logic [20:0]                                pc,
   output logic [20:0]                                return_stack_top,
   output logic [$clog2(STACK_DEPTH+1)-1:0]           stack_level,
   output var  opdec_pkg::stage_t                     stage,
   // System control
   output logic                                       timeout_status_bit,
   output logic                                       powerdown_status_bit,
   output logic                                       global_high_irq_enable,
   output logic                                       peripheral_low_irq_enable,
   output logic                                       standby,
   output logic                                       watchdog_clear,
   output logic                                       prescaler_clear,
   output logic                                       soft_reset
);
   localparam int PTR_W = $clog2(STACK_DEPTH+1);

   if (STACK_DEPTH < 2 || STACK_DEPTH > 255) begin : g_depth_check
      $error("STACK_DEPTH out of range");
   end

   opdec_pkg::stage_t   next_state;
   opdec_pkg::flags_t   next_flags;
   opdec_pkg::file_wr_t next_fw;
   opdec_pkg::flags_t   shadow_flags;
   logic [20:0]         next_pc;
   logic [7:0]          next_acc;
   logic [7:0]          shadow_acc;
   logic [7:0]          low_target;
   logic [7:0]          next_low;
   logic                pend_call;
   logic                next_call;
   logic                pend_fast;
   logic                next_fast;
   logic [20:0]         stack_mem [STACK_DEPTH];
   logic [20:0]         push_val;
   logic                push_en;
   logic                pop_en;
   logic                run;
   logic                byte_op;
   logic                bit_op;
   logic                skip;
   logic                taken;
   logic                clr_wdt;
   logic                go_sleep;
   logic                do_reset;
   logic                irq_ret;
   logic                restore;
   logic                save;
   logic [7:0]          operand;
   logic [7:0]          res;
   logic [7:0]          bit_mask;
   logic [7:0]          sub_a;
   logic [7:0]          sub_b;
   logic                sub_cin;
   logic [8:0]          sub_sum;
   logic [4:0]          sub_nib;
   logic [3:0]          bank;
   logic [3:0]          nib;

   assign nib = op.word[15:12];
   // Standby freezes execution; only wake or srst lets it go
   assign run = op.valid && !standby && (stage == opdec_pkg::ST_EXEC);

   always_comb begin
      next_state = stage;
      next_pc = pc;
      next_acc = working_accumulator;
      next_flags = flags;
      next_fw = '0;
      next_low = low_target;
      next_call = pend_call;
      next_fast = pend_fast;
      push_en = 1'h0;
      push_val = pc + opdec_pkg::PC_STEP;
      pop_en = 1'h0;
      byte_op = 1'h0;
      bit_op = 1'h0;
      skip = 1'h0;
      taken = 1'h0;
      clr_wdt = 1'h0;
      go_sleep = 1'h0;
      do_reset = 1'h0;
      irq_ret = 1'h0;
      restore = 1'h0;
      save = 1'h0;
      res = 8'h00;
      operand = op.is_port ? op.pin_data : op.file_data;
      bit_mask = 8'h01 << op.word[11:9];
      // Reversed operand order only for the file-from-accumulator form
      sub_a = (op.word[11:10] == opdec_pkg::SEL_SUB_F_FROM_A_B) ? working_accumulator : operand;
      sub_b = (op.word[11:10] == opdec_pkg::SEL_SUB_F_FROM_A_B) ? operand : working_accumulator;
      sub_cin = (op.word[11:10] == opdec_pkg::SEL_SUB_A_FROM_F) ? 1'h1 : flags.c;
      sub_sum = {1'h0, sub_a} + {1'h0, ~sub_b} + {8'h00, sub_cin};
      sub_nib = {1'h0, sub_a[3:0]} + {1'h0, ~sub_b[3:0]} + {4'h0, sub_cin};
      if (!op.word[8]) begin
         bank = (op.word[7:0] >= opdec_pkg::ACCESS_SPLIT) ? opdec_pkg::ACCESS_HIGH_BANK
                                                           : opdec_pkg::ACCESS_LOW_BANK;
      end else begin
         bank = bank_select;
      end
      unique case (op.word[10:9])
         2'h0: taken = flags.z ^ op.word[8];
         2'h1: taken = flags.c ^ op.word[8];
         2'h2: taken = flags.ov ^ op.word[8];
         2'h3: taken = flags.n ^ op.word[8];
      endcase
      if (stage == opdec_pkg::ST_DEAD) begin
         next_state = opdec_pkg::ST_EXEC;
      end else if (stage == opdec_pkg::ST_SKIP && op.valid) begin
         next_pc = pc + opdec_pkg::PC_STEP;
         next_state = opdec_pkg::ST_EXEC;
      end else if (stage == opdec_pkg::ST_SECOND && op.valid) begin
         next_pc = {op.word[11:0], low_target, 1'h0};
         push_en = pend_call;
         push_val = pc + opdec_pkg::PC_STEP;
         save = pend_call && pend_fast;
         next_state = opdec_pkg::ST_EXEC;
      end else if (run) begin
         next_pc = pc + opdec_pkg::PC_STEP;
         unique case (nib)
            opdec_pkg::NIB_CONTROL: begin
               if (op.word == opdec_pkg::W_WDT_CLEAR) begin
                  clr_wdt = 1'h1;
               end else if (op.word == opdec_pkg::W_STANDBY) begin
                  go_sleep = 1'h1;
               end else if (op.word == opdec_pkg::W_PUSH) begin
                  push_en = 1'h1;
               end else if (op.word == opdec_pkg::W_POP) begin
                  pop_en = 1'h1;
               end else if (op.word == opdec_pkg::W_SOFT_RESET) begin
                  do_reset = 1'h1;
               end else if (op.word[15:1] == opdec_pkg::W_IRQ_RETURN) begin
                  irq_ret = 1'h1;
                  restore = op.word[0];
                  pop_en = 1'h1;
                  next_pc = return_stack_top;
                  next_state = opdec_pkg::ST_DEAD;
               end else if (op.word[15:1] == opdec_pkg::W_SUB_RETURN) begin
                  restore = op.word[0];
                  pop_en = 1'h1;
                  next_pc = return_stack_top;
                  next_state = opdec_pkg::ST_DEAD;
               end else if (op.word[11:8] == opdec_pkg::SUB_LIT_RETURN) begin
                  next_acc = op.word[7:0];
                  pop_en = 1'h1;
                  next_pc = return_stack_top;
                  next_state = opdec_pkg::ST_DEAD;
               end
            end
            opdec_pkg::NIB_ROT_CARRY: begin
               if (op.word[11:10] == opdec_pkg::SEL_ROT_LEFT) begin
                  byte_op = 1'h1;
                  res = {operand[6:0], flags.c};
                  next_flags.c = operand[7];
               end else if (op.word[11:10] == opdec_pkg::SEL_ROT_RIGHT) begin
                  byte_op = 1'h1;
                  res = {flags.c, operand[7:1]};
                  next_flags.c = operand[0];
               end
            end
            opdec_pkg::NIB_ROT_PLAIN: begin
               if (op.word[11:10] == opdec_pkg::SEL_ROT_LEFT) begin
                  byte_op = 1'h1;
                  res = {operand[6:0], operand[7]};
               end else if (op.word[11:10] == opdec_pkg::SEL_ROT_RIGHT) begin
                  byte_op = 1'h1;
                  res = {operand[0], operand[7:1]};
               end
            end
            opdec_pkg::NIB_SUB: begin
               if (op.word[11:10] != 2'h0) begin
                  byte_op = 1'h1;
                  res = sub_sum[7:0];
                  next_flags.c = sub_sum[8];
                  next_flags.dc = sub_nib[4];
                  next_flags.ov = (sub_a[7] != sub_b[7]) && (sub_sum[7] != sub_a[7]);
               end
            end
            opdec_pkg::NIB_BIT_TOGGLE: begin
               bit_op = 1'h1;
               res = operand ^ bit_mask;
            end
            opdec_pkg::NIB_BIT_SET: begin
               bit_op = 1'h1;
               res = operand | bit_mask;
            end
            opdec_pkg::NIB_BIT_CLEAR: begin
               bit_op = 1'h1;
               res = operand & ~bit_mask;
            end
            opdec_pkg::NIB_TEST_CLEAR: skip = (operand & bit_mask) == 8'h00;
            opdec_pkg::NIB_TEST_SET: skip = (operand & bit_mask) != 8'h00;
            opdec_pkg::NIB_REL: begin
               // Return address is the word after the call
               next_pc = pc + opdec_pkg::PC_STEP + {{9{op.word[10]}}, op.word[10:0], 1'h0};
               push_en = op.word[11];
               next_state = opdec_pkg::ST_DEAD;
            end
            opdec_pkg::NIB_BRANCH: begin
               if (op.word[11:9] == opdec_pkg::SUB_CALL || op.word[11:8] == opdec_pkg::SUB_GOTO) begin
                  next_low = op.word[7:0];
                  next_call = (op.word[11:8] != opdec_pkg::SUB_GOTO);
                  next_fast = op.word[8];
                  next_state = opdec_pkg::ST_SECOND;
               end else if (!op.word[11] && taken) begin
                  next_pc = pc + opdec_pkg::PC_STEP + {{12{op.word[7]}}, op.word[7:0], 1'h0};
                  next_state = opdec_pkg::ST_DEAD;
               end
            end
            opdec_pkg::NIB_SECOND: next_pc = pc + opdec_pkg::PC_STEP;
            default: next_pc = pc + opdec_pkg::PC_STEP;
         endcase
         if (skip) begin
            next_state = opdec_pkg::ST_SKIP;
         end
         if (byte_op) begin
            next_flags.z = (res == 8'h00);
            next_flags.n = res[7];
         end
         if (bit_op || (byte_op && op.word[9])) begin
            next_fw = {1'h1, bank, op.word[7:0], res};
         end else if (byte_op) begin
            next_acc = res;
         end
      end
   end

   // Program flow
   always_ff @(posedge core_clk) begin
      if (srst || do_reset) begin
         stage <= opdec_pkg::ST_EXEC;
         pc <= opdec_pkg::PC_RST;
         low_target <= 8'h00;
         pend_call <= 1'h0;
         pend_fast <= 1'h0;
      end else begin
         stage <= next_state;
         pc <= next_pc;
         low_target <= next_low;
         pend_call <= next_call;
         pend_fast <= next_fast;
      end
   end

   // Accumulator, flags and fast-context shadow
   always_ff @(posedge core_clk) begin
      if (srst || do_reset) begin
         working_accumulator <= opdec_pkg::ACC_RST;
         flags <= opdec_pkg::FLAGS_RST;
         shadow_acc <= opdec_pkg::ACC_RST;
         shadow_flags <= opdec_pkg::FLAGS_RST;
         file_wr <= '0;
      end else begin
         working_accumulator <= restore ? shadow_acc : next_acc;
         flags <= restore ? shadow_flags : next_flags;
         file_wr <= next_fw;
         if (save) begin
            shadow_acc <= working_accumulator;
            shadow_flags <= flags;
         end
      end
   end

   // Return stack; pushes beyond the depth are dropped, pops on empty ignored
   always_ff @(posedge core_clk) begin
      if (push_en && stack_level != PTR_W'(STACK_DEPTH)) begin
         stack_mem[stack_level] <= push_val;
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst || do_reset) begin
         stack_level <= '0;
         return_stack_top <= opdec_pkg::PC_RST;
      end else if (push_en && stack_level != PTR_W'(STACK_DEPTH)) begin
         stack_level <= stack_level + PTR_W'(1);
         return_stack_top <= push_val;
      end else if (pop_en && stack_level != '0) begin
         stack_level <= stack_level - PTR_W'(1);
         return_stack_top <= (stack_level > PTR_W'(1)) ? stack_mem[stack_level - PTR_W'(2)]
                                                       : opdec_pkg::PC_RST;
      end
   end

   // System control bits and one-cycle strobes
   always_ff @(posedge core_clk) begin
      if (srst || do_reset) begin
         timeout_status_bit <= opdec_pkg::STATUS_BIT_RST;
         powerdown_status_bit <= opdec_pkg::STATUS_BIT_RST;
         global_high_irq_enable <= 1'h0;
         peripheral_low_irq_enable <= 1'h0;
         standby <= 1'h0;
         watchdog_clear <= 1'h0;
         prescaler_clear <= 1'h0;
      end else begin
         watchdog_clear <= clr_wdt || go_sleep;
         prescaler_clear <= op.is_timer_zero_count && prescaler_assigned && next_fw.en;
         if (clr_wdt || go_sleep) begin
            timeout_status_bit <= 1'h1;
            powerdown_status_bit <= !go_sleep;
         end
         if (go_sleep) begin
            standby <= 1'h1;
         end else if (wake) begin
            standby <= 1'h0;
         end
         if (irq_ret && !global_high_irq_enable) begin
            global_high_irq_enable <= 1'h1;
         end else if (irq_ret) begin
            peripheral_low_irq_enable <= 1'h1;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (srst) begin
         soft_reset <= 1'h0;
      end else begin
         soft_reset <= do_reset;
      end
   end

   default clocking @(posedge core_clk); endclocking
   default disable iff (srst);

   chk_rot_left_carry: assert property (run && nib == 4'h3 && op.word[11:10] == 2'h1
      |=> flags.c == $past(operand[7]) && flags.z == ($past(res) == 8'h00))
      else $error("rotate left carry wrong");
   chk_rot_right_carry: assert property (run && nib == 4'h3 && op.word[11:10] == 2'h0
      |=> flags.c == $past(operand[0]) && flags.n == $past(flags.c))
      else $error("rotate right carry wrong");
   chk_plain_rot_keeps: assert property (run && nib == 4'h4 && !op.word[11]
      |=> $stable(flags.c) && $stable(flags.ov) && flags.n == $past(res[7]))
      else $error("plain rotate touched carry");
   chk_sub_flags: assert property (run && nib == 4'h5 && op.word[11:10] != 2'h0
      |=> flags.c == $past(sub_sum[8]) && flags.dc == $past(sub_nib[4]))
      else $error("subtract flags wrong");
   chk_branch_dead_slot: assert property (run && nib == 4'hE && !op.word[11] && taken
      |=> stage == opdec_pkg::ST_DEAD ##1 stage == opdec_pkg::ST_EXEC)
      else $error("taken branch not two cycles");
   chk_call_second_word: assert property (stage == opdec_pkg::ST_SECOND && op.valid
      |=> pc == {$past(op.word[11:0]), $past(low_target), 1'h0} && stage == opdec_pkg::ST_EXEC)
      else $error("two-word target wrong");
   chk_skip_slot: assert property (run && nib == 4'hA && skip
      |=> stage == opdec_pkg::ST_SKIP && $stable(flags))
      else $error("skip did not take a slot");
   chk_prescaler_clear: assert property (run && byte_op && op.word[9] && op.is_timer_zero_count
      && prescaler_assigned |=> prescaler_clear && file_wr.en)
      else $error("prescaler not cleared");
   chk_standby_bits: assert property (run && op.word == 16'h0003
      |=> standby && !powerdown_status_bit && timeout_status_bit)
      else $error("standby bits wrong");
   chk_rel_target: assert property (run && nib == 4'hD
      |=> pc == $past(pc) + 21'h000002 + {{9{$past(op.word[10])}}, $past(op.word[10:0]), 1'h0})
      else $error("relative target wrong");

   cov_taken_branch: cover property (run && nib == 4'hE && !op.word[11] && taken);
   cov_call_return: cover property (stage == opdec_pkg::ST_SECOND && pend_call ##[1:50] pop_en);
   cov_skip_two_word: cover property (stage == opdec_pkg::ST_SKIP ##1 run && nib == 4'hF);
   cov_sleep_wake: cover property (standby ##[1:20] !standby);
endmodule : opcode_exec
`default_nettype wire

// ===== tb/risc_opcode_decode_control_tb_top.sv
// Directed bench for the opcode execute block: rotates, subtracts, skips, branches, calls, system ops.
// Assumes opdec_pkg and opcode_exec are compiled first; the bench acts as the fetcher.
`timescale 1ns/10ps
`default_nettype none
module risc_opcode_decode_control_tb_top;
   logic                core_clk = 1'b0;
   logic                srst = 1'b1;
   opdec_pkg::op_in_t   op = '0;
   logic [3:0]          bank_select = 4'h0;
   logic                prescaler_assigned = 1'b0;
   logic                wake = 1'b0;
   opdec_pkg::file_wr_t file_wr;
   opdec_pkg::flags_t   flags;
   opdec_pkg::stage_t   stage;
   logic [7:0]          acc;
   logic [20:0]         pc, stk_top, p;
   logic [4:0]          stack_level;
   logic                tout_bit, pdown_bit, irq_hi, irq_lo, standby, wd_clr, psc_clr, soft_reset;
   int                  mismatches = 0;
   int                  num_checks = 0;

   always #5 core_clk = ~core_clk;

   opcode_exec dut (.core_clk(core_clk), .srst(srst), .op(op), .bank_select(bank_select),
      .prescaler_assigned(prescaler_assigned), .wake(wake), .file_wr(file_wr), .working_accumulator(acc),
      .flags(flags), .pc(pc), .return_stack_top(stk_top), .stack_level(stack_level), .stage(stage),
      .timeout_status_bit(tout_bit), .powerdown_status_bit(pdown_bit), .global_high_irq_enable(irq_hi),
      .peripheral_low_irq_enable(irq_lo), .standby(standby), .watchdog_clear(wd_clr),
      .prescaler_clear(psc_clr), .soft_reset(soft_reset));

   task automatic chk(input string nm, input logic [20:0] e, input logic [20:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Pin data is the inverse of the latch so a port operand shows which one was used
   task automatic issue(input logic [15:0] w, input logic [7:0] fd, input logic [1:0] kind);
      @(posedge core_clk);
      op <= '{word: w, valid: 1'b1, file_data: fd, pin_data: ~fd, is_port: kind[1], is_timer_zero_count: kind[0]};
      @(posedge core_clk);
      op.valid <= 1'b0;
      #1;
   endtask : issue

   task automatic test_done();
      if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : test_done

   // Table of file ops with d=1 on f=0x10; carry chains from row to row, accumulator stays 0
   task automatic t_file_ops();
      logic [15:0] w [7] = '{16'h3610, 16'h3210, 16'h4610, 16'h4210, 16'h5A10, 16'h5E10, 16'h5610};
      logic [7:0]  fd [7] = '{8'h81, 8'h00, 8'h80, 8'h01, 8'h00, 8'h05, 8'h01};
      logic [7:0]  r [7] = '{8'h02, 8'h80, 8'h01, 8'h80, 8'hFF, 8'h05, 8'hFF};
      logic        c [7] = '{1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      for (int i = 0; i < 7; i++) begin
         issue(w[i], fd[i], 2'b00);
         chk("wr_data", 21'(r[i]), 21'(file_wr.data));
         chk("wr_addr", 21'h000010, 21'({file_wr.en, file_wr.addr}) ^ 21'h001000);
         chk("flag_c", 21'(c[i]), 21'(flags.c));
         chk("flag_zn", 21'({r[i] == 8'h00, r[i][7]}), 21'({flags.z, flags.n}));
      end
   endtask : t_file_ops

   task automatic t_port_timer_bits();
      issue(16'h4410, 8'h81, 2'b10);
      chk("acc_port", 21'h0000FC, 21'({file_wr.en, acc}));
      @(posedge core_clk);
      bank_select <= 4'h5;
      prescaler_assigned <= 1'b1;
      issue(16'h3790, 8'h00, 2'b01);
      chk("bank_addr", 21'h000590, 21'(file_wr.addr));
      chk("psc_clr", 21'h1, 21'(psc_clr));
      issue(16'h9210, 8'hFF, 2'b00);
      chk("bit_clear", 21'h0000FD, 21'(file_wr.data));
      chk("bit_flags", 21'h000002, 21'({flags.z, flags.n}));
      issue(16'h7E10, 8'h0F, 2'b00);
      chk("bit_toggle", 21'h00008F, 21'(file_wr.data));
      issue(16'h8010, 8'h00, 2'b00);
      chk("bit_set", 21'h000001, 21'(file_wr.data));
      issue(16'hB010, 8'hFE, 2'b00);
      chk("no_skip", 21'(opdec_pkg::ST_EXEC), 21'(stage));
      p = pc;
      issue(16'hA010, 8'hFE, 2'b00);
      chk("skip_stage", 21'(opdec_pkg::ST_SKIP), 21'(stage));
      issue(16'h3610, 8'h81, 2'b00);
      chk("skipped", p + 21'h4, pc | 21'(file_wr.en));
   endtask : t_port_timer_bits

   // After the bit clear: z=1 c=0 ov=0 n=0
   task automatic t_branches();
      logic [7:0] tk = 8'hA9;
      for (int i = 0; i < 8; i++) begin
         p = pc;
         issue(16'hE002 | 16'(i << 8), 8'h00, 2'b00);
         chk("br_pc", p + (tk[i] ? 21'h6 : 21'h2), pc);
         @(posedge core_clk);
      end
      p = pc;
      issue(16'hD7FF, 8'h00, 2'b00);
      chk("bra_pc", p, pc);
      chk("dead", 21'(opdec_pkg::ST_DEAD), 21'(stage));
      @(posedge core_clk);
      issue(16'hD801, 8'h00, 2'b00);
      chk("relative_subroutine_call_pc", p + 21'h4, pc);
      chk("relative_subroutine_call_top", p + 21'h2, stk_top);
      @(posedge core_clk);
      issue(16'h0012, 8'h00, 2'b00);
      chk("return_pc", p + 21'h2, pc);
      chk("return_level", 21'h000000, 21'(stack_level));
      @(posedge core_clk);
      p = pc;
      issue(16'hEC05, 8'h00, 2'b00);
      issue(16'hF001, 8'h00, 2'b00);
      chk("call_pc", 21'h00020A, pc);
      chk("call_top", p + 21'h4, stk_top);
      issue(16'h0006, 8'h00, 2'b00);
      chk("pop", 21'h0, 21'(stack_level));
      issue(16'h0005, 8'h00, 2'b00);
      chk("push_level", 21'h000001, 21'(stack_level));
      chk("push_top", 21'h00020E, stk_top);
      issue(16'hEF10, 8'h00, 2'b00);
      issue(16'hF002, 8'h00, 2'b00);
      chk("goto", 21'h000420, pc);
      issue(16'hF123, 8'h00, 2'b00);
      chk("lone_pc", 21'h000422, pc);
      chk("lone_stage", 21'(opdec_pkg::ST_EXEC), 21'(stage));
      issue(16'h0C5A, 8'h00, 2'b00);
      chk("lit_ret_pc", 21'h00020E, pc);
      chk("lit_ret_acc", 21'h00005A, 21'(acc));
      @(posedge core_clk);
   endtask : t_branches

   task automatic t_system();
      logic seen;
      issue(16'h0003, 8'h00, 2'b00);
      chk("standby", 21'h00000D, 21'({standby, tout_bit, pdown_bit, wd_clr}));
      p = pc;
      issue(16'h3610, 8'h81, 2'b00);
      chk("sleep_hold", p, pc);
      @(posedge core_clk);
      wake <= 1'b1;
      issue(16'h0004, 8'h00, 2'b00);
      @(posedge core_clk);
      wake <= 1'b0;
      issue(16'h0004, 8'h00, 2'b00);
      chk("wd_clear", 21'h000007, 21'({standby, tout_bit, pdown_bit, wd_clr}));
      issue(16'h0010, 8'h00, 2'b00);
      chk("irq_ret", 21'h000002, 21'({irq_hi, irq_lo}));
      @(posedge core_clk);
      issue(16'h00FF, 8'h00, 2'b00);
      seen = soft_reset;
      @(posedge core_clk);
      #1;
      chk("soft_pulse", 21'h000002, 21'({seen, soft_reset}));
      chk("soft_state", 21'h000002, 21'({tout_bit, irq_hi}));
      chk("soft_stack", 21'h000000, 21'(stack_level) | pc);
   endtask : t_system

   initial begin
      #20000;
      mismatches++;
      test_done();
   end

   initial begin
      repeat (16) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      chk("reset_pc", 21'h000000, pc);
      chk("reset_bits", 21'h000003, 21'({tout_bit, pdown_bit}));
      t_file_ops();
      t_port_timer_bits();
      t_branches();
      t_system();
      test_done();
   end
endmodule : risc_opcode_decode_control_tb_top
`default_nettype wire
